// file: hdl/sfo_pkg.sv
/*
 * Shared constants for the serial flash operation timing block: clock rate,
 * operation durations and their cycle counts, opcodes, status bit positions
 * and the state and operation encodings.
 * Assumes a single system clock of 125 MHz; every count below is derived from it.
 */
`default_nettype none

package sfo_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and counter widths
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned NS_PER_US     = 1000;
	localparam int unsigned NS_PER_MS     = 1000000;
	localparam int unsigned CNT_W         = 24;

	////////////////////////////////////////////////////////////////////////////////
	// Times as printed
	localparam int unsigned SLEEP_ENTRY_MAX_US     = 3;
	localparam int unsigned SLEEP_RELEASE_MAX_US   = 8;
	localparam int unsigned STATUS_WRITE_TYP_MS    = 8;
	localparam int unsigned STATUS_WRITE_MAX_MS    = 12;
	localparam int unsigned RESET_RECOVERY_MIN_US  = 70;
	localparam int unsigned SUSPEND_LATENCY_MAX_US = 30;
	localparam int unsigned PAGE_WRITE_TYP_MS      = 2;
	localparam int unsigned PAGE_WRITE_MAX_MS      = 3;
	localparam int unsigned WIPE_TYP_MS            = 10;
	localparam int unsigned WIPE_MAX_MS            = 12;

	////////////////////////////////////////////////////////////////////////////////
	// Cycle counts: longest times round down, least times round up
	localparam int unsigned SLEEP_ENTRY_CYC   = SLEEP_ENTRY_MAX_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int unsigned SLEEP_RELEASE_CYC = SLEEP_RELEASE_MAX_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int unsigned SUSPEND_CYC       = SUSPEND_LATENCY_MAX_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int unsigned STATUS_WRITE_MAX_CYC = STATUS_WRITE_MAX_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned PAGE_WRITE_MAX_CYC   = PAGE_WRITE_MAX_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned WIPE_MAX_CYC         = WIPE_MAX_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam logic [CNT_W-1:0] STATUS_WRITE_CYC =
		CNT_W'(STATUS_WRITE_TYP_MS * NS_PER_MS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] PAGE_WRITE_CYC =
		CNT_W'(PAGE_WRITE_TYP_MS * NS_PER_MS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] WIPE_CYC =
		CNT_W'(WIPE_TYP_MS * NS_PER_MS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] RESET_RECOVERY_CYC =
		CNT_W'((RESET_RECOVERY_MIN_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	////////////////////////////////////////////////////////////////////////////////
	// Opcodes
	localparam logic [7:0] OPC_PAGE_WRITE           = 8'h02;
	localparam logic [7:0] OPC_TWO_WIRE_PAGE_WRITE  = 8'ha2;
	localparam logic [7:0] OPC_FOUR_WIRE_PAGE_WRITE = 8'h32;
	localparam logic [7:0] OPC_PAGE_WIPE            = 8'h81;
	localparam logic [7:0] OPC_SECTOR_WIPE          = 8'h20;
	localparam logic [7:0] OPC_HALF_BLOCK_WIPE      = 8'h52;
	localparam logic [7:0] OPC_BLOCK_WIPE           = 8'hd8;
	localparam logic [7:0] OPC_CHIP_WIPE_A          = 8'h60;
	localparam logic [7:0] OPC_CHIP_WIPE_B          = 8'hc7;
	localparam logic [7:0] OPC_STATUS_WRITE         = 8'h01;
	localparam logic [7:0] OPC_STATUS_READ          = 8'h05;
	localparam logic [7:0] OPC_SUSPEND_A            = 8'h75;
	localparam logic [7:0] OPC_SUSPEND_B            = 8'hb0;
	localparam logic [7:0] OPC_RESUME_A             = 8'h7a;
	localparam logic [7:0] OPC_RESUME_B             = 8'h30;
	localparam logic [7:0] OPC_RESET_ENABLE         = 8'h66;
	localparam logic [7:0] OPC_RESET                = 8'h99;
	localparam logic [7:0] OPC_DEEP_SLEEP_ENTRY     = 8'hb9;
	localparam logic [7:0] OPC_DEEP_SLEEP_RELEASE   = 8'hab;

	////////////////////////////////////////////////////////////////////////////////
	// Status byte layout and pin idle levels
	localparam int unsigned STAT_BUSY_BIT    = 0;
	localparam int unsigned STAT_SUSPEND_BIT = 7;
	localparam logic [2:0]  PIN_IDLE         = 3'b100;

	////////////////////////////////////////////////////////////////////////////////
	// Encodings
	typedef enum logic [2:0] {
		ST_IDLE        = 3'b000,
		ST_BUSY        = 3'b001,
		ST_SUSPENDING  = 3'b011,
		ST_SUSPENDED   = 3'b010,
		ST_SLEEP_ENTER = 3'b100,
		ST_SLEEP       = 3'b101,
		ST_WAKING      = 3'b111,
		ST_RECOVER     = 3'b110
	} sfo_state_t;

	typedef enum logic [1:0] {
		OP_NONE = 2'h0,
		OP_PROG = 2'h1,
		OP_WIPE = 2'h2,
		OP_SRW  = 2'h3
	} sfo_op_t;

endpackage : sfo_pkg

`default_nettype wire

// file: hdl/sfo_sync.sv
/*
 * Two-stage synchroniser for a bundle of pin inputs.
 * Assumes the pins are asynchronous to sys_clk; the first stage is read only by the second.
 */
`timescale 1ns/100ps
`default_nettype none

module sfo_sync #(
	parameter int unsigned  W        = 1,
	parameter logic [W-1:0] RST_VAL  = '0
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         reset,
	// Pins in, synchronised copy out
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_sync
);

	logic [W-1:0] meta_q;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			meta_q   <= RST_VAL;
			pin_sync <= RST_VAL;
		end else begin
			meta_q   <= pin_in;
			pin_sync <= meta_q;
		end
	end

endmodule : sfo_sync

`default_nettype wire

// file: hdl/sfo_timing.sv
/*
 * Operation timing core of a serial flash: decodes opcodes from the serial pins and
 * times program, wipe, status write, suspend, deep sleep and command reset; reports
 * busy and suspend state in the status byte returned by a status read.
 * Assumes serial mode 0 with the serial clock well below a quarter of sys_clk.
 */
// What this block does
// - Deep sleep is reached within 3 us after chip select rises on the entry command.
// - Standby returns within 8 us after the release command, and the host waits that long.
// - A status write stays busy typically 8 ms, at most 12 ms.
// - A reset during program or wipe leaves the device not ready for at least 70 us.
// - A reset during a status write recovers in the status write cycle time, 8 ms typical, 12 ms at most.
// - A suspend completes within 30 us and then the operation is halted.
// - Suspend and resume are accepted any number of times during one program or wipe; a status write is never suspended.
// - A page write of up to 256 bytes stays busy typically 2 ms, at most 3 ms.
// - Every wipe type stays busy typically 10 ms, at most 12 ms.
`timescale 1ns/100ps
`default_nettype none

module sfo_timing #(
	parameter logic [sfo_pkg::CNT_W-1:0] PAGE_WRITE_CYCLES     = sfo_pkg::PAGE_WRITE_CYC,
	parameter logic [sfo_pkg::CNT_W-1:0] WIPE_CYCLES           = sfo_pkg::WIPE_CYC,
	parameter logic [sfo_pkg::CNT_W-1:0] STATUS_WRITE_CYCLES   = sfo_pkg::STATUS_WRITE_CYC,
	parameter logic [sfo_pkg::CNT_W-1:0] RESET_RECOVERY_CYCLES = sfo_pkg::RESET_RECOVERY_CYC
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic reset,
	// Serial pins from the host
	input  wire logic spi_sclk,
	input  wire logic spi_cs_n,
	input  wire logic spi_mosi,
	// Serial data back to the host
	output logic      spi_miso,
	output logic      spi_miso_oe,
	// Operation state
	output logic      status_busy,
	output logic      op_suspended,
	output logic      in_deep_sleep
);

	import sfo_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Pin sampling and edges

	logic [2:0]       pin_s;
	logic             cs_n_s;
	logic             sclk_s;
	logic             mosi_s;
	logic             sclk_prev_q;
	logic             cs_prev_q;
	logic             sclk_rise;
	logic             sclk_fall;
	logic             cs_rise;

	sfo_sync #(
		.W       (3),
		.RST_VAL (PIN_IDLE)
	) u_pin_sync (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.pin_in   ({spi_cs_n, spi_sclk, spi_mosi}),
		.pin_sync (pin_s)
	);

	assign {cs_n_s, sclk_s, mosi_s} = pin_s;
	assign sclk_rise = sclk_s & ~sclk_prev_q;
	assign sclk_fall = ~sclk_s & sclk_prev_q;
	assign cs_rise   = cs_n_s & ~cs_prev_q;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sclk_prev_q <= 1'b0;
			cs_prev_q   <= 1'b1;
		end else begin
			sclk_prev_q <= sclk_s;
			cs_prev_q   <= cs_n_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Opcode capture

	logic [3:0]       bit_cnt_q;
	logic [7:0]       shift_q;
	logic [7:0]       opc_q;
	logic             have_opc;
	logic             cmd_done;
	logic             rst_en_q;
	logic             reset_cmd;
	logic             asleep;
	sfo_state_t       state_q;

	assign have_opc = bit_cnt_q[3];
	// Commands take effect when chip select rises after a whole opcode
	assign cmd_done = cs_rise & have_opc;
	assign asleep   = (state_q == ST_SLEEP_ENTER) || (state_q == ST_SLEEP) ||
	                  (state_q == ST_WAKING);
	assign reset_cmd = cmd_done && (opc_q == OPC_RESET) && rst_en_q;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			bit_cnt_q <= 4'h0;
			shift_q   <= 8'h00;
			opc_q     <= 8'h00;
		end else if (cs_n_s) begin
			bit_cnt_q <= 4'h0;
		end else if (sclk_rise) begin
			shift_q <= {shift_q[6:0], mosi_s};
			// Wraps within 8..15 so byte boundaries stay visible in long reads
			bit_cnt_q <= (bit_cnt_q == 4'hf) ? 4'h8 : bit_cnt_q + 4'h1;
			if (bit_cnt_q == 4'h7) begin
				opc_q <= {shift_q[6:0], mosi_s};
			end
		end
	end

	// Reset must come directly after its enable
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rst_en_q <= 1'b0;
		end else if (cmd_done) begin
			rst_en_q <= (opc_q == OPC_RESET_ENABLE) && !asleep;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decoding

	function automatic sfo_op_t op_of(input logic [7:0] opc);
		case (opc)
			OPC_PAGE_WRITE, OPC_TWO_WIRE_PAGE_WRITE, OPC_FOUR_WIRE_PAGE_WRITE: op_of = OP_PROG;
			OPC_PAGE_WIPE, OPC_SECTOR_WIPE, OPC_HALF_BLOCK_WIPE, OPC_BLOCK_WIPE,
			OPC_CHIP_WIPE_A, OPC_CHIP_WIPE_B: op_of = OP_WIPE;
			OPC_STATUS_WRITE: op_of = OP_SRW;
			default: op_of = OP_NONE;
		endcase
	endfunction : op_of

	function automatic logic [CNT_W-1:0] op_len(input sfo_op_t op);
		case (op)
			OP_PROG: op_len = PAGE_WRITE_CYCLES;
			OP_WIPE: op_len = WIPE_CYCLES;
			OP_SRW:  op_len = STATUS_WRITE_CYCLES;
			default: op_len = '0;
		endcase
	endfunction : op_len

	function automatic logic is_resume(input logic [7:0] opc);
		is_resume = (opc == OPC_RESUME_A) || (opc == OPC_RESUME_B);
	endfunction : is_resume

	////////////////////////////////////////////////////////////////////////////////
	// Operation sequencer

	sfo_op_t          op_q;
	logic [CNT_W-1:0] op_cnt_q;
	logic [CNT_W-1:0] tmr_q;
	logic [CNT_W-1:0] recover_len;

	// A status write interrupted by reset needs its full cycle to settle
	assign recover_len = (op_q == OP_SRW) ? STATUS_WRITE_CYCLES : RESET_RECOVERY_CYCLES;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_q  <= ST_IDLE;
			op_q     <= OP_NONE;
			op_cnt_q <= '0;
			tmr_q    <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (cmd_done && op_of(opc_q) != OP_NONE) begin
						state_q  <= ST_BUSY;
						op_q     <= op_of(opc_q);
						op_cnt_q <= op_len(op_of(opc_q));
					end else if (cmd_done && opc_q == OPC_DEEP_SLEEP_ENTRY) begin
						state_q <= ST_SLEEP_ENTER;
						tmr_q   <= CNT_W'(SLEEP_ENTRY_CYC);
					end
				end
				ST_BUSY: begin
					op_cnt_q <= op_cnt_q - 1'b1;
					if (reset_cmd) begin
						state_q <= ST_RECOVER;
						tmr_q   <= recover_len;
					end else if (op_cnt_q <= 1) begin
						state_q <= ST_IDLE;
						op_q    <= OP_NONE;
					end else if (cmd_done && op_q != OP_SRW &&
					             (opc_q == OPC_SUSPEND_A || opc_q == OPC_SUSPEND_B)) begin
						state_q <= ST_SUSPENDING;
						tmr_q   <= CNT_W'(SUSPEND_CYC);
					end
				end
				ST_SUSPENDING: begin
					// Operation still runs until the latency ends; it may finish first
					op_cnt_q <= op_cnt_q - 1'b1;
					tmr_q    <= tmr_q - 1'b1;
					if (reset_cmd) begin
						state_q <= ST_RECOVER;
						tmr_q   <= recover_len;
					end else if (op_cnt_q <= 1) begin
						state_q <= ST_IDLE;
						op_q    <= OP_NONE;
					end else if (tmr_q <= 1) begin
						state_q <= ST_SUSPENDED;
					end
				end
				ST_SUSPENDED: begin
					if (reset_cmd) begin
						state_q <= ST_RECOVER;
						tmr_q   <= recover_len;
					end else if (cmd_done && is_resume(opc_q)) begin
						state_q <= ST_BUSY;
					end
				end
				ST_SLEEP_ENTER: begin
					tmr_q <= tmr_q - 1'b1;
					if (tmr_q <= 1) begin
						state_q <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (cmd_done && opc_q == OPC_DEEP_SLEEP_RELEASE) begin
						state_q <= ST_WAKING;
						tmr_q   <= CNT_W'(SLEEP_RELEASE_CYC);
					end
				end
				ST_WAKING: begin
					tmr_q <= tmr_q - 1'b1;
					if (tmr_q <= 1) begin
						state_q <= ST_IDLE;
					end
				end
				ST_RECOVER: begin
					tmr_q <= tmr_q - 1'b1;
					if (tmr_q <= 1) begin
						state_q  <= ST_IDLE;
						op_q     <= OP_NONE;
						op_cnt_q <= '0;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status flags and status read

	logic [7:0]       stat_live;
	logic [7:0]       stat_sh_q;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			status_busy   <= 1'b0;
			op_suspended  <= 1'b0;
			in_deep_sleep <= 1'b0;
		end else begin
			status_busy   <= (state_q == ST_BUSY) || (state_q == ST_SUSPENDING) ||
			                 (state_q == ST_RECOVER);
			op_suspended  <= (state_q == ST_SUSPENDED);
			in_deep_sleep <= (state_q == ST_SLEEP);
		end
	end

	always_comb begin
		stat_live                   = 8'h00;
		stat_live[STAT_BUSY_BIT]    = status_busy;
		stat_live[STAT_SUSPEND_BIT] = op_suspended;
	end

	// Status repeats each byte and is refreshed at every byte boundary
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			spi_miso    <= 1'b0;
			spi_miso_oe <= 1'b0;
			stat_sh_q   <= 8'h00;
		end else if (cs_n_s || asleep) begin
			spi_miso_oe <= 1'b0;
		end else if (sclk_fall && have_opc && opc_q == OPC_STATUS_READ) begin
			spi_miso_oe <= 1'b1;
			if (bit_cnt_q[2:0] == 3'h0) begin
				spi_miso  <= stat_live[7];
				stat_sh_q <= {stat_live[6:0], 1'b0};
			end else begin
				spi_miso  <= stat_sh_q[7];
				stat_sh_q <= {stat_sh_q[6:0], 1'b0};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	localparam int A_SLEEP_MAX = SLEEP_ENTRY_CYC + 1;
	localparam int A_WAKE_MAX  = SLEEP_RELEASE_CYC;

	sfo_state_t       prev_state_q;
	logic [CNT_W-1:0] stay_q;

	// Cycles spent in the current state
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prev_state_q <= ST_IDLE;
			stay_q       <= '0;
		end else begin
			prev_state_q <= state_q;
			stay_q       <= (prev_state_q != state_q) ? '0 : stay_q + 1'b1;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_sleep_entry: assert property ($rose(state_q == ST_SLEEP_ENTER) |->
		##[1:A_SLEEP_MAX] in_deep_sleep)
		else $error("deep sleep not reached in time");
	a_wake_time: assert property ($rose(state_q == ST_WAKING) |->
		##[1:A_WAKE_MAX] (state_q == ST_IDLE))
		else $error("release from deep sleep too slow");
	// The stay count is stale in a state's first cycle, so that cycle is skipped
	a_status_write_len: assert property ((state_q == ST_BUSY && op_q == OP_SRW &&
		prev_state_q == state_q) |->
		stay_q < STATUS_WRITE_MAX_CYC)
		else $error("status write busy too long");
	a_recover_len: assert property ($rose(state_q == ST_RECOVER) |->
		tmr_q == ((op_q == OP_SRW) ? STATUS_WRITE_CYCLES : RESET_RECOVERY_CYCLES))
		else $error("wrong reset recovery length");
	a_recover_busy: assert property ($rose(state_q == ST_RECOVER) |=>
		status_busy [*2])
		else $error("not busy during reset recovery");
	a_suspend_latency: assert property ((state_q == ST_SUSPENDING &&
		prev_state_q == state_q) |->
		stay_q < SUSPEND_CYC)
		else $error("suspend latency exceeded");
	a_suspend_halts: assert property ((state_q == ST_SUSPENDED &&
		prev_state_q == ST_SUSPENDED) |-> $stable(op_cnt_q))
		else $error("suspended operation still counting");
	a_resume_again: assert property ((state_q == ST_SUSPENDED && cmd_done &&
		is_resume(opc_q) && !reset_cmd) |=> (state_q == ST_BUSY) ##1 status_busy)
		else $error("resume not accepted");
	a_page_write_len: assert property ((state_q == ST_BUSY && op_q == OP_PROG &&
		prev_state_q == state_q) |->
		stay_q < PAGE_WRITE_MAX_CYC)
		else $error("page write busy too long");
	a_wipe_len: assert property ((state_q == ST_BUSY && op_q == OP_WIPE &&
		prev_state_q == state_q) |->
		stay_q < WIPE_MAX_CYC)
		else $error("wipe busy too long");
	a_busy_report: assert property ((state_q == ST_BUSY) |=>
		status_busy && !op_suspended)
		else $error("busy not reported");

endmodule : sfo_timing

`default_nettype wire

// file: verification/serial_flash_operation_timing_test.sv
/*
 * Self-checking bench for sfo_timing with shortened operation counts.
 * Assumes sfo_pkg and sfo_host_model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module serial_flash_operation_timing_test;
	import sfo_pkg::*;

	localparam logic [CNT_W-1:0] PW_N = 24'h001068;
	localparam logic [CNT_W-1:0] WP_N = 24'h002328;
	localparam logic [CNT_W-1:0] SW_N = 24'h0004b0;
	localparam logic [CNT_W-1:0] RR_N = 24'h000064;
	localparam int PW = int'(PW_N);
	localparam int WP = int'(WP_N);
	localparam int SW = int'(SW_N);
	localparam int RR = int'(RR_N);
	localparam int TIMEOUT_CYC = 98000;

	typedef struct {
		logic [31:0] val;
		int          lo;
		int          hi;
		bit          rel;
	} sfo_note_t;

	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	wire  logic  spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
	wire  logic  status_busy, op_suspended, in_deep_sleep, rd_strobe;
	wire  logic [7:0] rd_byte;
	wire  logic [2:0] flags = {status_busy, op_suspended, in_deep_sleep};
	logic [2:0]  prev;
	logic [31:0] seed = 32'h000104ea;
	int          cyc = 0;
	int          last_chg, base, busy_cnt = 0, err_count = 0, num_checks = 0;
	int          busy_base;
	sfo_note_t   n;
	sfo_note_t   flag_q[$];
	logic [31:0] byte_q[$];
	logic [7:0]  wipe_ops[6] = '{OPC_PAGE_WIPE, OPC_SECTOR_WIPE, OPC_HALF_BLOCK_WIPE,
		OPC_BLOCK_WIPE, OPC_CHIP_WIPE_A, OPC_CHIP_WIPE_B};

	always #4 sys_clk = ~sys_clk;

	sfo_timing #(
		.PAGE_WRITE_CYCLES    (PW_N),
		.WIPE_CYCLES          (WP_N),
		.STATUS_WRITE_CYCLES  (SW_N),
		.RESET_RECOVERY_CYCLES(RR_N)
	) sfo_timing_inst (
		.sys_clk      (sys_clk),
		.reset        (reset),
		.spi_sclk     (spi_sclk),
		.spi_cs_n     (spi_cs_n),
		.spi_mosi     (spi_mosi),
		.spi_miso     (spi_miso),
		.spi_miso_oe  (spi_miso_oe),
		.status_busy  (status_busy),
		.op_suspended (op_suspended),
		.in_deep_sleep(in_deep_sleep)
	);

	sfo_host_model #(.PRS_NS(2000.0), .ERS_NS(4000.0)) sfo_host_model_inst (
		.spi_sclk   (spi_sclk),
		.spi_cs_n   (spi_cs_n),
		.spi_mosi   (spi_mosi),
		.spi_miso   (spi_miso),
		.spi_miso_oe(spi_miso_oe),
		.rd_strobe  (rd_strobe),
		.rd_byte    (rd_byte)
	);

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got,
		input bit in_time);
		num_checks++;
		if (got !== exp || !in_time) begin
			err_count++;
			$display("mismatch %s expected %0h seen %0h in_time %0d cycle %0d", what, exp, got,
				in_time, cyc);
		end
	endtask : compare

	task automatic conclude();
		err_count += flag_q.size() + byte_q.size();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////////////
	// Monitor: every flag change consumes the oldest note, every status byte the oldest expected byte
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		busy_cnt <= busy_cnt + ((status_busy === 1'b1) ? 1 : 0);
		if (cyc == TIMEOUT_CYC) begin
			err_count++;
			conclude();
		end
		if (reset) begin
			prev <= 3'h0;
		end else if (flags !== prev) begin
			prev <= flags;
			last_chg <= cyc;
			if (flag_q.size() == 0) begin
				compare("flags", 32'hff, {29'h0, flags}, 1'b0);
			end else begin
				n = flag_q.pop_front();
				base = n.rel ? last_chg : 0;
				compare("flags", n.val, {29'h0, flags}, cyc >= base + n.lo && cyc <= base + n.hi);
			end
		end
	end

	always @(posedge rd_strobe) begin
		if (byte_q.size() == 0) begin
			compare("status", 32'hff, {24'h0, rd_byte}, 1'b0);
		end else begin
			compare("status", byte_q.pop_front(), {24'h0, rd_byte}, 1'b1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Driver
	task automatic expect_flags(input logic [2:0] val, input int lo, input int hi, input bit rel);
		flag_q.push_back('{{29'h0, val}, rel ? lo : cyc + lo, rel ? hi : cyc + hi, rel});
	endtask : expect_flags

	task automatic status(input logic [7:0] val);
		byte_q.push_back({24'h0, val});
		sfo_host_model_inst.xfer(OPC_STATUS_READ, 32'h0, 1'b0, 1'b1);
	endtask : status

	task automatic cmd(input logic [7:0] op, input logic [31:0] tail, input bit has_tail);
		sfo_host_model_inst.xfer(op, tail, has_tail, 1'b0);
	endtask : cmd

	task automatic wait_flags(input logic [2:0] val, input int max);
		for (int i = 0; i < max && flags !== val; i++) @(negedge sys_clk);
	endtask : wait_flags

	task automatic reset_cmd();
		cmd(OPC_RESET_ENABLE, 32'h0, 1'b0);
		cmd(OPC_RESET, 32'h0, 1'b0);
	endtask : reset_cmd

	initial begin
		repeat (8) @(negedge sys_clk);
		reset = 1'b0;
		repeat (4) @(negedge sys_clk);
		status(8'h00);
		reset_cmd();
		status(8'h00);
		// Page write; a wipe sent meanwhile must be ignored
		cmd(OPC_PAGE_WRITE, rnd(), 1'b1);
		expect_flags(3'b100, 2, 9, 1'b0);
		expect_flags(3'b000, PW, PW, 1'b1);
		status(8'h01);
		cmd(OPC_SECTOR_WIPE, rnd(), 1'b1);
		wait_flags(3'b000, PW + 50);
		foreach (wipe_ops[i]) begin
			cmd(wipe_ops[i], rnd(), 1'b1);
			expect_flags(3'b100, 2, 9, 1'b0);
			expect_flags(3'b000, WP, WP, 1'b1);
			wait_flags(3'b100, 20);
			wait_flags(3'b000, WP + 50);
		end
		cmd(OPC_STATUS_WRITE, rnd(), 1'b1);
		expect_flags(3'b100, 2, 9, 1'b0);
		expect_flags(3'b000, SW, SW, 1'b1);
		wait_flags(3'b100, 20);
		wait_flags(3'b000, SW + 50);
		// Reset during a status write keeps the full write time
		cmd(OPC_STATUS_WRITE, rnd(), 1'b1);
		expect_flags(3'b100, 2, 9, 1'b0);
		reset_cmd();
		expect_flags(3'b000, SW + 2, SW + 9, 1'b0);
		wait_flags(3'b000, SW + 50);
		// Wipe suspended twice; progress kept across both
		busy_base = busy_cnt;
		cmd(OPC_BLOCK_WIPE, rnd(), 1'b1);
		expect_flags(3'b100, 2, 9, 1'b0);
		wait_flags(3'b100, 20);
		for (int k = 0; k < 2; k++) begin
			sfo_host_model_inst.suspend(1'b1, k ? OPC_SUSPEND_B : OPC_SUSPEND_A);
			expect_flags(3'b010, 2, SUSPEND_CYC + 7, 1'b0);
			wait_flags(3'b010, SUSPEND_CYC + 20);
			status(8'h80);
			sfo_host_model_inst.resume(k ? OPC_RESUME_B : OPC_RESUME_A);
			expect_flags(3'b100, 2, 9, 1'b0);
		end
		expect_flags(3'b000, 1, WP, 1'b0);
		wait_flags(3'b000, WP);
		compare("busy_cycles", 32'h1, {31'h0, busy_cnt - busy_base inside {[WP:WP + 12]}}, 1'b1);
		// Program suspended, then reset out of the suspension
		cmd(OPC_FOUR_WIRE_PAGE_WRITE, rnd(), 1'b1);
		expect_flags(3'b100, 2, 9, 1'b0);
		wait_flags(3'b100, 20);
		sfo_host_model_inst.suspend(1'b0, OPC_SUSPEND_A);
		expect_flags(3'b010, 2, SUSPEND_CYC + 7, 1'b0);
		wait_flags(3'b010, SUSPEND_CYC + 20);
		cmd(OPC_PAGE_WRITE, rnd(), 1'b1);
		reset_cmd();
		expect_flags(3'b100, 2, 9, 1'b0);
		expect_flags(3'b000, RR, RR + 1, 1'b1);
		wait_flags(3'b000, RR + 50);
		// Deep sleep ignores a page write; release returns to standby
		cmd(OPC_DEEP_SLEEP_ENTRY, 32'h0, 1'b0);
		expect_flags(3'b001, 2, SLEEP_ENTRY_CYC + 6, 1'b0);
		wait_flags(3'b001, SLEEP_ENTRY_CYC + 20);
		cmd(OPC_PAGE_WRITE, rnd(), 1'b1);
		expect_flags(3'b000, 2, SLEEP_RELEASE_CYC + 250, 1'b0);
		sfo_host_model_inst.release_sleep(OPC_DEEP_SLEEP_RELEASE);
		status(8'h00);
		conclude();
	end

endmodule : serial_flash_operation_timing_test

`default_nettype wire

// file: verification/sfo_host_model.sv
/*
 * Serial host model for the flash timing block: mode 0 frames, status reads.
 * Assumes the bench calls one task at a time and pins are sampled by sys_clk.
 */
`timescale 1ns/100ps
`default_nettype none

module sfo_host_model #(
	parameter real HALF_NS    = 80.0,
	parameter real GAP_NS     = 203.3,
	parameter real RELEASE_NS = 8000.0,
	parameter real PRS_NS     = 100000.0,
	parameter real ERS_NS     = 200000.0
) (
	// Serial pins
	output logic       spi_sclk,
	output logic       spi_cs_n,
	output logic       spi_mosi,
	input  wire logic  spi_miso,
	input  wire logic  spi_miso_oe,
	// Status byte read back
	output logic       rd_strobe,
	output logic [7:0] rd_byte
);
	real last_resume;

	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
		rd_strobe = 1'b0;
		rd_byte = 8'h00;
		last_resume = -1.0e9;
	end

	// 6.25 MHz link clock, far below every class limit
	task automatic xfer(input logic [7:0] op, input logic [31:0] tail, input bit has_tail,
		input bit rd);
		logic [39:0] sh;
		int          nb;
		sh = {op, tail};
		nb = has_tail ? 40 : 8;
		#(GAP_NS) spi_cs_n = 1'b0;
		for (int i = 0; i < nb; i++) begin
			spi_mosi = sh[39-i];
			#(HALF_NS) spi_sclk = 1'b1;
			#(HALF_NS) spi_sclk = 1'b0;
		end
		for (int i = 0; i < 8 && rd; i++) begin
			spi_mosi = ~spi_mosi;
			#(HALF_NS) spi_sclk = 1'b1;
			rd_byte[7-i] = spi_miso_oe ? spi_miso : 1'bx;
			#(HALF_NS) spi_sclk = 1'b0;
		end
		#(HALF_NS) spi_cs_n = 1'b1;
		// Deselected data line must not keep its last level
		spi_mosi = ~spi_mosi;
		rd_strobe = rd;
		#1 rd_strobe = 1'b0;
	endtask : xfer

	task automatic suspend(input bit wipe, input logic [7:0] op);
		while ($realtime - last_resume < (wipe ? ERS_NS : PRS_NS)) #(HALF_NS);
		xfer(op, 32'h0, 1'b0, 1'b0);
	endtask : suspend

	task automatic resume(input logic [7:0] op);
		xfer(op, 32'h0, 1'b0, 1'b0);
		last_resume = $realtime;
	endtask : resume

	task automatic release_sleep(input logic [7:0] op);
		xfer(op, 32'h0, 1'b0, 1'b0);
		#(RELEASE_NS);
	endtask : release_sleep

endmodule : sfo_host_model

`default_nettype wire
